// ==== core/cmpmx_top.sv ====
// Comparator control block: register file, input routing, edge events and interrupt.
//
// Behaviour
// - Result reads one when selected positive input exceeds selected negative input.
// - Raw result is synchronised, adding one to two clocks of latency.
// - Read-only result sits at bit 5 of the control/status register.
// - Writing one to bit 7 powers the comparator off, allowed any time.
// - Bit 6 routes the internal reference to the positive input instead of a pin.
// - Bit 4 event flag sets when a result change matches the chosen edge.
// - Interrupt requested only with flag, enable bit, enable mask register and global enable all set.
// - Flag clears on vector execution or on a written one; zero leaves it.
// - Enable bit 3 allows the interrupt when one, blocks it when zero.
// - Mode bits 1:0 pick toggle, reserved, falling or rising edge.
// - Mux enable with converter off lets the channel mux feed the negative input.
// - Mux mode: channels 0..63 feed negative; pair field picks positive pin.
// - Otherwise the pair field selects both pins per the fixed pair table.
// - Pair field occupies bits 2:0 of the second control register.
`timescale 1ns/1ps

module cmpmx_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cmpmx_pkg::CMPMX_ADDR_W-1:0] PADDR,
  input wire logic [cmpmx_pkg::CMPMX_DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [cmpmx_pkg::CMPMX_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Processor interrupt interface
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic IRQ_VECTOR_ACK,
  output logic IRQ,
  // Converter state shared with this block
  input wire logic CONVERTER_ENABLE,
  input wire logic [5:0] CONVERTER_CHANNEL_SELECT,
  // Analog comparator core and input switches
  input wire logic COMPARATOR_RAW,
  output logic COMPARATOR_POWER_OFF,
  output logic [1:0] POSITIVE_SOURCE,
  output logic NEGATIVE_FROM_CHANNEL_MUX,
  output logic [1:0] NEGATIVE_PIN,
  output logic [5:0] NEGATIVE_CHANNEL
);

  import cmpmx_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic result_prev;
    logic power_off;
    logic ref_pos;
    logic event_flag;
    logic irq_en;
    logic mux_en;
    logic [1:0] edge_sel;
    logic [2:0] pair_sel;
    logic irq_mask;
    logic [CMPMX_DATA_W-1:0] rdata;
    logic [1:0] pos_src;
    logic neg_mux;
    logic [1:0] neg_pin;
    logic [5:0] neg_chan;
  } cmpmx_state_t;

  cmpmx_state_t st_ff;
  cmpmx_state_t nxt_st;

  logic result_sync;
  logic setup_phase;
  logic access_phase;
  logic wr_lane0;
  logic rise;
  logic fall;
  logic edge_hit;
  logic clr_write;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Address decode is used for both read data and write strobes.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = reg_hit(addr, CMPMX_OFS_CTRL_STATUS) || reg_hit(addr, CMPMX_OFS_CTRL_SECOND) ||
                  reg_hit(addr, CMPMX_OFS_IRQ_STATUS) || reg_hit(addr, CMPMX_OFS_IRQ_CLEAR) ||
                  reg_hit(addr, CMPMX_OFS_IRQ_ENABLE);
  endfunction : addr_mapped

  // ----------------------------------------------------------------
  // Result synchroniser
  // ----------------------------------------------------------------

  // The core's raw decision is asynchronous to CLK; two stages give the
  // readable result a latency of one to two clocks.
  cmpmx_sync u_sync (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .ASYNC_IN(COMPARATOR_RAW),
    .SYNC_OUT(result_sync)
  );

  // ----------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------

  // Zero-wait slave: read data is captured in the setup cycle and the
  // access cycle always completes, so every transfer takes two clocks.
  assign setup_phase = PSEL && !PENABLE;
  assign access_phase = PSEL && PENABLE;
  assign wr_lane0 = access_phase && PWRITE && PSTRB[0];
  assign PREADY = 1'b1;
  assign PSLVERR = access_phase && !addr_mapped(PADDR[7:0]);
  assign PRDATA = st_ff.rdata;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------

  // Current and previous synchronised samples are compared every clock.
  assign rise = result_sync && !st_ff.result_prev;
  assign fall = !result_sync && st_ff.result_prev;

  // The reserved code matches no edge, so it can never set the flag.
  always_comb begin
    case (cmpmx_edge_t'(st_ff.edge_sel))
      CMPMX_EDGE_TOGGLE: edge_hit = rise || fall;
      CMPMX_EDGE_FALL: edge_hit = fall;
      CMPMX_EDGE_RISE: edge_hit = rise;
      CMPMX_EDGE_RESERVED: edge_hit = 1'b0;
      default: edge_hit = 1'b0;
    endcase
  end

  // A one written to the flag bit of the control register or to the
  // clear register removes the flag; a zero leaves it alone.
  assign clr_write = wr_lane0 &&
                     ((reg_hit(PADDR[7:0], CMPMX_OFS_CTRL_STATUS) && PWDATA[CMPMX_BIT_EVENT]) ||
                      (reg_hit(PADDR[7:0], CMPMX_OFS_IRQ_CLEAR) && PWDATA[CMPMX_BIT_IRQ_EVENT]));

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.result_prev = result_sync;

    // Event flag: hardware set wins over a clear in the same cycle, so
    // an edge that lands on the acknowledge is never lost.
    if (edge_hit) begin
      nxt_st.event_flag = 1'b1;
    end else if (clr_write || IRQ_VECTOR_ACK) begin
      nxt_st.event_flag = 1'b0;
    end

    // Register writes take effect at the completing edge of the access.
    if (wr_lane0 && reg_hit(PADDR[7:0], CMPMX_OFS_CTRL_STATUS)) begin
      nxt_st.power_off = PWDATA[CMPMX_BIT_POWER_OFF];
      nxt_st.ref_pos = PWDATA[CMPMX_BIT_REF_POS];
      nxt_st.irq_en = PWDATA[CMPMX_BIT_IRQ_EN];
      nxt_st.mux_en = PWDATA[CMPMX_BIT_MUX_EN];
      nxt_st.edge_sel = PWDATA[CMPMX_BIT_EDGE_HI:CMPMX_BIT_EDGE_LO];
    end
    if (wr_lane0 && reg_hit(PADDR[7:0], CMPMX_OFS_CTRL_SECOND)) begin
      nxt_st.pair_sel = PWDATA[CMPMX_PAIR_MSB:0];
    end
    if (wr_lane0 && reg_hit(PADDR[7:0], CMPMX_OFS_IRQ_ENABLE)) begin
      nxt_st.irq_mask = PWDATA[CMPMX_BIT_IRQ_EVENT];
    end

    // Read data is sampled in the setup cycle; unmapped and write-only
    // locations read as zero.
    if (setup_phase) begin
      nxt_st.rdata = '0;
      if (reg_hit(PADDR[7:0], CMPMX_OFS_CTRL_STATUS)) begin
        nxt_st.rdata[CMPMX_BIT_POWER_OFF] = st_ff.power_off;
        nxt_st.rdata[CMPMX_BIT_REF_POS] = st_ff.ref_pos;
        nxt_st.rdata[CMPMX_BIT_RESULT] = result_sync;
        nxt_st.rdata[CMPMX_BIT_EVENT] = st_ff.event_flag;
        nxt_st.rdata[CMPMX_BIT_IRQ_EN] = st_ff.irq_en;
        nxt_st.rdata[CMPMX_BIT_MUX_EN] = st_ff.mux_en;
        nxt_st.rdata[CMPMX_BIT_EDGE_HI:CMPMX_BIT_EDGE_LO] = st_ff.edge_sel;
      end else if (reg_hit(PADDR[7:0], CMPMX_OFS_CTRL_SECOND)) begin
        nxt_st.rdata[CMPMX_PAIR_MSB:0] = st_ff.pair_sel;
      end else if (reg_hit(PADDR[7:0], CMPMX_OFS_IRQ_STATUS)) begin
        nxt_st.rdata[CMPMX_BIT_IRQ_EVENT] = st_ff.event_flag;
      end else if (reg_hit(PADDR[7:0], CMPMX_OFS_IRQ_ENABLE)) begin
        nxt_st.rdata[CMPMX_BIT_IRQ_EVENT] = st_ff.irq_mask;
      end
    end

    // Input routing is recomputed from the current settings each clock,
    // so the analog switches follow a register write one clock later.
    nxt_st.neg_chan = CONVERTER_CHANNEL_SELECT;
    if (st_ff.mux_en && !CONVERTER_ENABLE) begin
      // The converter multiplexer supplies the negative side.
      nxt_st.neg_mux = 1'b1;
      nxt_st.neg_pin = CMPMX_SRC_PIN1;
      if (st_ff.pair_sel[2]) begin
        nxt_st.pos_src = CMPMX_SRC_PIN2;
      end else if (st_ff.pair_sel[1]) begin
        nxt_st.pos_src = CMPMX_SRC_PIN1;
      end else begin
        nxt_st.pos_src = CMPMX_SRC_PIN0;
      end
    end else begin
      // Both sides come from the dedicated pins.
      nxt_st.neg_mux = 1'b0;
      case (st_ff.pair_sel)
        3'h0: begin
          nxt_st.pos_src = CMPMX_SRC_PIN0;
          nxt_st.neg_pin = CMPMX_SRC_PIN1;
        end
        3'h1: begin
          nxt_st.pos_src = CMPMX_SRC_PIN0;
          nxt_st.neg_pin = CMPMX_SRC_PIN2;
        end
        3'h2: begin
          nxt_st.pos_src = CMPMX_SRC_PIN1;
          nxt_st.neg_pin = CMPMX_SRC_PIN0;
        end
        3'h3: begin
          nxt_st.pos_src = CMPMX_SRC_PIN1;
          nxt_st.neg_pin = CMPMX_SRC_PIN2;
        end
        3'h4: begin
          nxt_st.pos_src = CMPMX_SRC_PIN2;
          nxt_st.neg_pin = CMPMX_SRC_PIN0;
        end
        default: begin
          nxt_st.pos_src = CMPMX_SRC_PIN2;
          nxt_st.neg_pin = CMPMX_SRC_PIN1;
        end
      endcase
    end

    // The internal reference overrides whichever pin was chosen above.
    if (st_ff.ref_pos) begin
      nxt_st.pos_src = CMPMX_SRC_REF;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff.result_prev <= 1'b0;
      st_ff.power_off <= CMPMX_RST_CTRL_STATUS[CMPMX_BIT_POWER_OFF];
      st_ff.ref_pos <= CMPMX_RST_CTRL_STATUS[CMPMX_BIT_REF_POS];
      st_ff.event_flag <= CMPMX_RST_CTRL_STATUS[CMPMX_BIT_EVENT];
      st_ff.irq_en <= CMPMX_RST_CTRL_STATUS[CMPMX_BIT_IRQ_EN];
      st_ff.mux_en <= CMPMX_RST_CTRL_STATUS[CMPMX_BIT_MUX_EN];
      st_ff.edge_sel <= CMPMX_RST_CTRL_STATUS[CMPMX_BIT_EDGE_HI:CMPMX_BIT_EDGE_LO];
      st_ff.pair_sel <= CMPMX_RST_PAIR;
      st_ff.irq_mask <= CMPMX_RST_IRQ_MASK;
      st_ff.rdata <= '0;
      st_ff.pos_src <= CMPMX_SRC_PIN0;
      st_ff.neg_mux <= 1'b0;
      st_ff.neg_pin <= CMPMX_SRC_PIN1;
      st_ff.neg_chan <= 6'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // The interrupt needs the flag, the block enable, the status mask and
  // the processor's global enable together. Toggling power or the edge
  // mode can create a spurious edge, which is why software is expected
  // to drop the enable first; the hardware does not suppress it.
  assign IRQ = st_ff.event_flag && st_ff.irq_en && st_ff.irq_mask &&
               GLOBAL_IRQ_ENABLE;

  assign COMPARATOR_POWER_OFF = st_ff.power_off;
  assign POSITIVE_SOURCE = st_ff.pos_src;
  assign NEGATIVE_FROM_CHANNEL_MUX = st_ff.neg_mux;
  assign NEGATIVE_PIN = st_ff.neg_pin;
  assign NEGATIVE_CHANNEL = st_ff.neg_chan;

endmodule : cmpmx_top

// ==== core/cmpmx_pkg.sv ====
// Package of constants and types for the comparator control block.
package cmpmx_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned CMPMX_ADDR_W = 8;
  localparam int unsigned CMPMX_DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CMPMX_OFS_CTRL_STATUS = 8'h00; // comparator_control_status
  localparam logic [7:0] CMPMX_OFS_CTRL_SECOND = 8'h04; // comparator_control_second
  localparam logic [7:0] CMPMX_OFS_IRQ_STATUS = 8'h08; // Sticky event status, read only.
  localparam logic [7:0] CMPMX_OFS_IRQ_CLEAR = 8'h0c; // Write one to clear, reads zero.
  localparam logic [7:0] CMPMX_OFS_IRQ_ENABLE = 8'h10; // Interrupt enable mask.

  // ----------------------------------------------------------------
  // Field positions of comparator_control_status
  // ----------------------------------------------------------------
  localparam int unsigned CMPMX_BIT_POWER_OFF = 7;
  localparam int unsigned CMPMX_BIT_REF_POS = 6;
  localparam int unsigned CMPMX_BIT_RESULT = 5;
  localparam int unsigned CMPMX_BIT_EVENT = 4;
  localparam int unsigned CMPMX_BIT_IRQ_EN = 3;
  localparam int unsigned CMPMX_BIT_MUX_EN = 2;
  localparam int unsigned CMPMX_BIT_EDGE_HI = 1;
  localparam int unsigned CMPMX_BIT_EDGE_LO = 0;

  // Field of comparator_control_second and of the interrupt registers.
  localparam int unsigned CMPMX_PAIR_MSB = 2;
  localparam int unsigned CMPMX_BIT_IRQ_EVENT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMPMX_RST_CTRL_STATUS = 8'h00;
  localparam logic [2:0] CMPMX_RST_PAIR = 3'h0;
  localparam logic CMPMX_RST_IRQ_MASK = 1'b0;

  // ----------------------------------------------------------------
  // Edge modes and input selection codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMPMX_EDGE_TOGGLE = 2'b00,
    CMPMX_EDGE_RESERVED = 2'b01,
    CMPMX_EDGE_FALL = 2'b10,
    CMPMX_EDGE_RISE = 2'b11
  } cmpmx_edge_t;

  // Source codes for the analog input switches.
  localparam logic [1:0] CMPMX_SRC_PIN0 = 2'h0;
  localparam logic [1:0] CMPMX_SRC_PIN1 = 2'h1;
  localparam logic [1:0] CMPMX_SRC_PIN2 = 2'h2;
  localparam logic [1:0] CMPMX_SRC_REF = 2'h3;

endpackage : cmpmx_pkg

// ==== core/cmpmx_sync.sv ====
// Two-stage synchroniser for the raw comparator result.
`timescale 1ns/1ps

module cmpmx_sync (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Asynchronous level and its synchronised copy
  input wire logic ASYNC_IN,
  output logic SYNC_OUT
);

  logic meta_ff;
  logic sync_ff;

  // The first stage feeds only the second stage, so a metastable
  // value never reaches any decision logic.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= ASYNC_IN;
      sync_ff <= meta_ff;
    end
  end

  assign SYNC_OUT = sync_ff;

endmodule : cmpmx_sync

// ==== bench/cmpmx_sva.sv ====
// Concurrent checks on the ports of the comparator control block.
`timescale 1ns/1ps

module cmpmx_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cmpmx_pkg::CMPMX_ADDR_W-1:0] PADDR,
  input wire logic [cmpmx_pkg::CMPMX_DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [cmpmx_pkg::CMPMX_DATA_W-1:0] PRDATA,
  // Interrupt and converter side
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic IRQ_VECTOR_ACK,
  input wire logic IRQ,
  input wire logic CONVERTER_ENABLE,
  input wire logic [5:0] CONVERTER_CHANNEL_SELECT,
  // Analog core side
  input wire logic COMPARATOR_RAW,
  input wire logic COMPARATOR_POWER_OFF,
  input wire logic [1:0] POSITIVE_SOURCE,
  input wire logic NEGATIVE_FROM_CHANNEL_MUX,
  input wire logic [1:0] NEGATIVE_PIN,
  input wire logic [5:0] NEGATIVE_CHANNEL
);
  import cmpmx_pkg::*;

  typedef struct packed {logic raw; logic [2:0] st;} cmpmx_chk_t;
  cmpmx_chk_t s_ff;
  cmpmx_chk_t nxt_s;
  logic wr_ctrl;
  logic rd_ctrl;
  logic quiet;

  // Count edges with a steady raw result, so checks skip in-flight events.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.raw = COMPARATOR_RAW;
    if (COMPARATOR_RAW != s_ff.raw) begin
      nxt_s.st = 3'h0;
    end else if (s_ff.st != 3'h7) begin
      nxt_s.st = s_ff.st + 3'h1;
    end
  end

  // Helper state register.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Access-phase decodes of the control/status register.
  assign wr_ctrl = PSEL && PENABLE && PWRITE && PSTRB[0] && (PADDR == CMPMX_OFS_CTRL_STATUS);
  assign rd_ctrl = PSEL && PENABLE && !PWRITE && (PADDR == CMPMX_OFS_CTRL_STATUS);
  assign quiet = (s_ff.st >= 3'h6);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_IRQ_GATED: assert property (IRQ |-> GLOBAL_IRQ_ENABLE)
    else $error("interrupt raised without global enable");
  AST_IEN_BLOCKS: assert property (wr_ctrl && !PWDATA[3] |=> !IRQ)
    else $error("interrupt stays after enable bit cleared");
  AST_FLAG_W1C: assert property (wr_ctrl && PWDATA[4] && quiet |=> !IRQ)
    else $error("event flag not cleared by written one");
  AST_ACK_CLEARS: assert property (IRQ_VECTOR_ACK && quiet |=> !IRQ)
    else $error("event flag not cleared by vector");
  AST_RESULT_READ: assert property (rd_ctrl && quiet |-> PRDATA[5] == COMPARATOR_RAW)
    else $error("result bit differs from settled comparator");
  AST_POWER_OFF: assert property (wr_ctrl |-> ##2 COMPARATOR_POWER_OFF == $past(PWDATA[7], 2))
    else $error("power-off output does not follow bit 7");
  AST_REF_POS: assert property (wr_ctrl && PWDATA[6] |-> ##2 POSITIVE_SOURCE == CMPMX_SRC_REF)
    else $error("reference not routed to positive input");
  AST_MUX_NEG: assert property (NEGATIVE_FROM_CHANNEL_MUX |-> !$past(CONVERTER_ENABLE))
    else $error("channel mux used while converter enabled");
  AST_CHAN_COPY: assert property (NEGATIVE_CHANNEL == $past(CONVERTER_CHANNEL_SELECT))
    else $error("negative channel not one clock copy of select");
  AST_PAIR_DISTINCT: assert property (!NEGATIVE_FROM_CHANNEL_MUX |-> POSITIVE_SOURCE != NEGATIVE_PIN)
    else $error("pair table routes one pin to both inputs");

  // Main scenarios reached.
  CV_IRQ: cover property (IRQ);
  CV_RESULT_HIGH: cover property (rd_ctrl && PRDATA[5]);
  CV_MUX: cover property (NEGATIVE_FROM_CHANNEL_MUX);

endmodule : cmpmx_sva

bind cmpmx_top cmpmx_sva u_sva (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
  .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .IRQ_VECTOR_ACK(IRQ_VECTOR_ACK), .IRQ(IRQ),
  .CONVERTER_ENABLE(CONVERTER_ENABLE), .CONVERTER_CHANNEL_SELECT(CONVERTER_CHANNEL_SELECT),
  .COMPARATOR_RAW(COMPARATOR_RAW), .COMPARATOR_POWER_OFF(COMPARATOR_POWER_OFF),
  .POSITIVE_SOURCE(POSITIVE_SOURCE), .NEGATIVE_FROM_CHANNEL_MUX(NEGATIVE_FROM_CHANNEL_MUX),
  .NEGATIVE_PIN(NEGATIVE_PIN), .NEGATIVE_CHANNEL(NEGATIVE_CHANNEL));

// ==== bench/cmpmx_analog_model.sv ====
// Behavioural analog comparator core with its input switches.
`timescale 1ns/1ps

module cmpmx_analog_model (
  // Switch settings from the block
  input wire logic power_off,
  input wire logic [1:0] pos_src,
  input wire logic neg_mux,
  input wire logic [1:0] neg_pin,
  input wire logic [5:0] neg_chan,
  // Pin levels in millivolts
  input wire logic [11:0] v_pin0,
  input wire logic [11:0] v_pin1,
  input wire logic [11:0] v_pin2,
  // Decision towards the block
  output logic raw
);
  localparam logic [11:0] VREF = 12'h44c; // Internal reference, 1100 mV.
  logic [11:0] pos;
  logic [11:0] neg;

  // Channel pins sit on a 100 mV ramp so every channel code gives its own level.
  always_comb begin
    pos = (pos_src == 2'h3) ? VREF : (pos_src == 2'h0) ? v_pin0 : (pos_src == 2'h1) ? v_pin1 : v_pin2;
    neg = neg_mux ? 12'h064 * {6'h0, neg_chan} : (neg_pin == 2'h0) ? v_pin0 : (neg_pin == 2'h1) ? v_pin1 : v_pin2;
    raw = power_off ? 1'b0 : (pos > neg);
  end

endmodule : cmpmx_analog_model

// ==== bench/cmpmx_top_tb.sv ====
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps

module cmpmx_top_tb;
  import cmpmx_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, pen, pwr, gie, ack, cen, raw, pready, pslverr, irq, poff, nmux, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  logic [5:0] csel, nchan;
  logic [1:0] psrc, npin;
  logic [11:0] v0, v1, v2;
  logic [31:0] seed = 32'hc9f1;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int p, ch, m_ctrl, m_flag, fire;

  cmpmx_top u_dut (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .GLOBAL_IRQ_ENABLE(gie), .IRQ_VECTOR_ACK(ack), .IRQ(irq), .CONVERTER_ENABLE(cen),
    .CONVERTER_CHANNEL_SELECT(csel), .COMPARATOR_RAW(raw), .COMPARATOR_POWER_OFF(poff),
    .POSITIVE_SOURCE(psrc), .NEGATIVE_FROM_CHANNEL_MUX(nmux), .NEGATIVE_PIN(npin), .NEGATIVE_CHANNEL(nchan));

  cmpmx_analog_model u_core (.power_off(poff), .pos_src(psrc), .neg_mux(nmux), .neg_pin(npin),
    .neg_chan(nchan), .v_pin0(v0), .v_pin1(v1), .v_pin2(v2), .raw(raw));

  // 50 MHz clock.
  always #10 clk = ~clk;

  // Cut a hang short; the whole run needs a few hundred cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Pair table as {positive pin, negative pin}.
  function automatic int pair_exp(input int c);
    case (c)
      0: return 1;
      1: return 2;
      2: return 4;
      3: return 6;
      4: return 8;
      default: return 9;
    endcase
  endfunction : pair_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One bus transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // Drive pin 0 above or below pin 1 and let the result settle.
  task automatic setv(input logic up);
    @(posedge clk);
    v0 <= up ? 12'h2bc : 12'h064;
    idle(6);
  endtask : setv

  task automatic final_report();
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Main sequence.
  initial begin
    {psel, pen, pwr, gie, ack, cen} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    csel = 6'h00;
    v0 = 12'h064;
    v1 = 12'h1f4;
    v2 = 12'h12c;
    idle(8);
    rst_n <= 1'b1;
    rd(CMPMX_OFS_CTRL_STATUS, 32'h0);
    for (int i = 4; i <= 20; i += 4) begin
      rd(8'(i), 32'h0);
      chk(32'(rerr), 32'(i == 20));
    end
    for (int c = 0; c < 8; c++) begin
      wr_pair(c);
      chk(32'({psrc, npin}), 32'(pair_exp(c)));
      rd(CMPMX_OFS_CTRL_SECOND, 32'(c));
    end
    apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'h04);
    for (int k = 0; k < 6; k++) begin
      ch = int'(rnd() % 9);
      p = int'(rnd() % 8);
      @(posedge clk);
      csel <= 6'(ch);
      wr_pair(p);
      chk(32'({psrc, nmux, nchan}), 32'(((p < 2) ? 0 : (p < 4) ? 1 : 2) * 128 + 64 + ch));
    end
    @(posedge clk);
    cen <= 1'b1;
    idle(2);
    chk(32'({nmux, psrc, npin}), 32'(pair_exp(p)));
    apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'h40);
    idle(2);
    chk(32'(psrc), 32'h3);
    apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'h80);
    idle(2);
    chk(32'(poff), 32'h1);
    apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'h00);
    wr_pair(0);
    chk(32'(poff), 32'h0);
    gie <= 1'b1;
    apb(1'b1, CMPMX_OFS_IRQ_ENABLE, 32'h1);
    for (int m = 0; m < 4; m++) begin
      // Drop the enable under the old mode before the mode itself changes.
      apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'(m_ctrl & 3));
      apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'(m));
      apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'(m) | 32'h18);
      m_ctrl = m | 8;
      m_flag = 0;
      for (int e = 0; e < 2; e++) begin
        setv(e == 0);
        fire = int'(m == 0 || (m == 3 && e == 0) || (m == 2 && e == 1));
        m_flag = m_flag | fire;
        rd(CMPMX_OFS_CTRL_STATUS, 32'(m_ctrl | (int'(v0 > v1) << 5) | (m_flag << 4)));
        chk(32'(irq), 32'(m_flag));
      end
    end
    @(posedge clk);
    gie <= 1'b0;
    idle(1);
    chk(32'(irq), 32'h0);
    gie <= 1'b1;
    apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'h03);
    chk_irq(0);
    apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'h0b);
    chk_irq(1);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    chk_irq(0);
    setv(1'b0);
    setv(1'b1);
    chk_irq(1);
    apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'h1b);
    chk_irq(0);
    setv(1'b0);
    setv(1'b1);
    rd(CMPMX_OFS_IRQ_STATUS, 32'h1);
    apb(1'b1, CMPMX_OFS_IRQ_CLEAR, 32'h1);
    chk_irq(0);
    rd(CMPMX_OFS_IRQ_CLEAR, 32'h0);
    // A write without lane 0 must leave the control register alone.
    pstrb <= 4'he;
    apb(1'b1, CMPMX_OFS_CTRL_STATUS, 32'h0);
    pstrb <= 4'hf;
    rd(CMPMX_OFS_CTRL_STATUS, 32'h2b);
    final_report();
  end

  task automatic wr_pair(input int c);
    apb(1'b1, CMPMX_OFS_CTRL_SECOND, 32'(c));
    idle(2);
  endtask : wr_pair

  task automatic chk_irq(input int e);
    idle(1);
    chk(32'(irq), 32'(e));
  endtask : chk_irq

endmodule : cmpmx_top_tb
